/* shared/tc8_pkg.sv */
// Shared constants and types for the 8-bit timer/counter
`default_nettype none
package tc8_pkg;
  localparam int unsigned CHANNELS = 2;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_ONE    = 8'h01;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  // Register offsets
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] ADDR_COUNT  = 4'h2;
  localparam logic [3:0] ADDR_CMP_A  = 4'h3;
  localparam logic [3:0] ADDR_CMP_B  = 4'h4;
  localparam logic [3:0] ADDR_ASYNC  = 4'h5;
  localparam logic [3:0] ADDR_FLAGS  = 4'h6;
  localparam logic [3:0] ADDR_MASK   = 4'h7;
  // Field positions
  localparam int unsigned CA_WGM_LO = 0;
  localparam int unsigned CB_CS_LO  = 0;
  localparam int unsigned CB_WGM2   = 3;
  localparam int unsigned AS_SEL    = 0;
  localparam int unsigned FL_OVF    = 0;
  localparam int unsigned COM_LO [CHANNELS] = '{6, 4};
  localparam int unsigned FOC_BIT[CHANNELS] = '{7, 6};
  localparam int unsigned FL_BIT [CHANNELS] = '{1, 2};
  localparam logic [3:0]  CMP_ADDR[CHANNELS] = '{ADDR_CMP_A, ADDR_CMP_B};
  // Waveform mode codes
  localparam logic [2:0] MODE_NORMAL    = 3'h0;
  localparam logic [2:0] MODE_PC_MAX    = 3'h1;
  localparam logic [2:0] MODE_CTC       = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX  = 3'h3;
  localparam logic [2:0] MODE_PC_CMPA   = 3'h5;
  localparam logic [2:0] MODE_FAST_CMPA = 3'h7;
  // Output action codes
  localparam logic [1:0] COM_NONE   = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;
  // Tick source, prescale taps indexed by clock select
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [9:0] PRESC_ONE = 10'h001;
  localparam logic [7:0][9:0] PRESC_MASK = {10'h3FF, 10'h0FF, 10'h07F, 10'h03F,
                                            10'h01F, 10'h007, 10'h000, 10'h000};
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
endpackage : tc8_pkg
`default_nettype wire

/* logic/tick_select.sv */
// Tick source selection: I/O clock or sampled crystal, through the prescaler
`timescale 1ns/1ns
`default_nettype none
module tick_select import tc8_pkg::*; (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic [2:0] clock_select_field_i,
  input  wire logic       async_clock_select_i,
  // Crystal pins
  input  wire logic       crystal_osc_in_i,
  output logic            crystal_osc_out_o,
  // Tick
  output logic            timer_tick_o
);
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       prev;
    logic       osc_out;
    logic [9:0] presc;
  } tick_state_t;
  tick_state_t r, nxt;
  logic        base;
  logic [9:0]  tap;

  always_comb begin
    nxt       = r;
    nxt.s1    = crystal_osc_in_i;
    nxt.s2    = r.s1;
    nxt.prev  = r.s2;
    nxt.osc_out = ~r.s2;
    // R06 crystal edge or I/O clock
    base = async_clock_select_i ? (r.s2 & ~r.prev) : 1'b1;
    if (base) begin
      nxt.presc = r.presc + PRESC_ONE;
    end
    tap = PRESC_MASK[clock_select_field_i];
    // R07 no source means no tick
    timer_tick_o = base && (clock_select_field_i != CS_STOP) && ((r.presc & tap) == tap);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign crystal_osc_out_o = r.osc_out;
endmodule : tick_select
`default_nettype wire

/* logic/compare_channel.sv */
// One output compare channel: buffer, compare value, match and output register
`timescale 1ns/1ns
`default_nettype none
module compare_channel import tc8_pkg::*; (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Counter state
  input  wire logic [7:0] count_i,
  input  wire logic       tick_i,
  input  wire logic       block_i,
  input  wire logic       at_top_i,
  input  wire logic       down_i,
  input  wire logic [2:0] mode_i,
  // Software side
  input  wire logic [1:0] action_i,
  input  wire logic       force_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  // Results
  output logic [7:0]      compare_value_o,
  output logic [7:0]      buffer_o,
  output logic            match_o,
  output logic            compare_output_o
);
  typedef struct packed {
    logic [7:0] cmp;
    logic [7:0] bufv;
    logic       oc;
  } chan_state_t;
  chan_state_t r, nxt;
  logic pwm, fast, hit, top_tick;

  always_comb begin
    nxt  = r;
    pwm  = mode_i[0];
    fast = mode_i[1] & mode_i[0];
    // R12 R18 match at the tick, unless blocked by a count write
    match_o  = tick_i && (count_i == r.cmp) && !block_i;
    top_tick = tick_i && at_top_i;
    // R16 direct access when not buffered
    if (wr_i) begin
      nxt.bufv = wdata_i;
      if (!pwm) begin
        nxt.cmp = wdata_i;
      end
    end
    // R15 buffered value lands at top of count
    if (pwm && top_tick) begin
      nxt.cmp = r.bufv;
    end
    // Bottom action in fast PWM comes first, a match overrides it
    if (fast && top_tick) begin
      if (action_i == COM_CLEAR) begin
        nxt.oc = 1'b1;
      end else if (action_i == COM_SET) begin
        nxt.oc = 1'b0;
      end
    end
    // R17 force acts like a match on the output only
    hit = match_o || (force_i && !pwm);
    // R20 R26 action field read live, zero leaves output alone
    if (hit) begin
      case (action_i)
        COM_TOGGLE: if (!pwm) nxt.oc = ~r.oc;
        COM_CLEAR:  nxt.oc = (pwm && !fast) ? down_i : 1'b0;
        COM_SET:    nxt.oc = (pwm && !fast) ? ~down_i : 1'b1;
        default:    nxt.oc = r.oc;
      endcase
    end
  end

  // R19 output register never reset by a mode change
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign compare_value_o  = r.cmp;
  assign buffer_o         = r.bufv;
  assign compare_output_o = r.oc;
endmodule : compare_channel
`default_nettype wire

/* logic/timer8.sv */
// 8-bit timer/counter with two compare channels and register port
//
// Overview of operation
// R01 - Count of zero is bottom
// R02 - Count of 255 is the maximum
// R03 - Top is maximum or compare A, by mode
// R04 - Counter and compare registers are 8 bits
// R05 - Each request has a flag and mask
// R06 - Async select picks crystal tick source
// R07 - Clock select zero stops the counter
// R08 - Counter readable and writable at all times
// R09 - Counter write beats any tick update
// R10 - Tick clears, increments or decrements per mode
// R11 - Mode field split across two controls
// R12 - Equality sets match flag next tick
// R13 - Enabled flag requests; clears when serviced
// R14 - Writing one clears a flag
// R15 - PWM compare values double buffered
// R16 - Access reaches buffer or compare directly
// R17 - Force updates output, no flag
// R18 - Counter write blocks next tick's matches
// R19 - Output registers survive mode changes
// R20 - Output action field acts immediately
// R21 - Software avoids loading matching counts
// R22 - Software sets outputs before pin direction
// R23 - Normal mode wraps, overflow at zero
// R24 - Mode two clears on compare A
// R25 - Fast PWM codes three and seven
// R26 - Action zero leaves output unchanged
// R27 - Crystal tick crossed safely into clock
// R28 - Acknowledge input clears each flag
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module timer8 import tc8_pkg::*; (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Register port
  input  wire reg_req_t   req_i,
  output logic [7:0]      rdata_o,
  // Crystal pins
  input  wire logic       crystal_osc_in_i,
  output logic            crystal_osc_out_o,
  // Compare outputs
  output logic            compare_output_a_o,
  output logic            compare_output_b_o,
  // Interrupt requests and acknowledges
  output logic [2:0]      irq_o,
  input  wire logic [2:0] irq_ack_i
);
  typedef struct packed {
    logic [7:0] control_reg_a;
    logic [2:0] clock_select_field;
    logic       waveform_mode_bit2;
    logic       async_clock_select;
    // R04 8-bit count register
    logic [7:0] count_value;
    logic       down;
    logic       block;
    logic [2:0] interrupt_flag_reg;
    logic [2:0] interrupt_mask_reg;
    logic [7:0] rdata;
  } timer_state_t;
  timer_state_t r, nxt;

  logic       timer_tick;
  logic [2:0] waveform_mode_field;
  logic [7:0] top_value;
  logic       at_top, at_bottom, phase_mode, count_wr, ovf_evt;
  logic [2:0] flag_set, flag_clr;
  logic [7:0] read_val;
  logic [CHANNELS-1:0]      match_evt;
  logic [CHANNELS-1:0]      oc;
  logic [CHANNELS-1:0][7:0] cmp_val;
  logic [CHANNELS-1:0][7:0] buf_val;

  // R11 mode bits from both controls
  assign waveform_mode_field = {r.waveform_mode_bit2, r.control_reg_a[CA_WGM_LO +: 2]};
  assign phase_mode = (waveform_mode_field == MODE_PC_MAX) ||
                      (waveform_mode_field == MODE_PC_CMPA);
  // R03 R24 R25 top selection
  assign top_value = ((waveform_mode_field == MODE_CTC) ||
                      (waveform_mode_field == MODE_FAST_CMPA) ||
                      (waveform_mode_field == MODE_PC_CMPA)) ? cmp_val[0] : CNT_MAX;
  assign at_top    = (r.count_value == top_value);
  // R01 bottom indication
  assign at_bottom = (r.count_value == CNT_BOTTOM);
  assign count_wr  = req_i.wr && (req_i.addr == ADDR_COUNT);

  // R06 R27 tick source, crystal sampled through a two-stage synchroniser
  tick_select u_tick (
    .clk_i                (clk_i),
    .rst_n_i              (rst_n_i),
    .clock_select_field_i (r.clock_select_field),
    .async_clock_select_i (r.async_clock_select),
    .crystal_osc_in_i     (crystal_osc_in_i),
    .crystal_osc_out_o    (crystal_osc_out_o),
    .timer_tick_o         (timer_tick)
  );

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    compare_channel u_chan (
      .clk_i            (clk_i),
      .rst_n_i          (rst_n_i),
      .count_i          (r.count_value),
      .tick_i           (timer_tick),
      .block_i          (r.block),
      .at_top_i         (at_top),
      .down_i           (r.down),
      .mode_i           (waveform_mode_field),
      .action_i         (r.control_reg_a[COM_LO[ch] +: 2]),
      .force_i          (req_i.wr && (req_i.addr == ADDR_CTRL_B) && req_i.wdata[FOC_BIT[ch]]),
      .wr_i             (req_i.wr && (req_i.addr == CMP_ADDR[ch])),
      .wdata_i          (req_i.wdata),
      .compare_value_o  (cmp_val[ch]),
      .buffer_o         (buf_val[ch]),
      .match_o          (match_evt[ch]),
      .compare_output_o (oc[ch])
    );
    assign flag_set[FL_BIT[ch]] = match_evt[ch];
  end

  // R23 overflow: at the maximum (at top in fast PWM) for single slope, at bottom turn for dual slope
  always_comb begin
    if (phase_mode) begin
      ovf_evt = timer_tick && r.down && at_bottom;
    end else if (waveform_mode_field[0]) begin
      ovf_evt = timer_tick && at_top;
    end else begin
      ovf_evt = timer_tick && (r.count_value == CNT_MAX);
    end
  end
  assign flag_set[FL_OVF] = ovf_evt;

  // R14 R28 software write-one and acknowledge both clear
  assign flag_clr = irq_ack_i |
                    ((req_i.wr && (req_i.addr == ADDR_FLAGS)) ? req_i.wdata[2:0] : 3'h0);

  always_comb begin
    case (req_i.addr)
      ADDR_CTRL_A: read_val = r.control_reg_a;
      ADDR_CTRL_B: read_val = {4'h0, r.waveform_mode_bit2, r.clock_select_field};
      ADDR_COUNT:  read_val = r.count_value;
      ADDR_CMP_A:  read_val = buf_val[0];
      ADDR_CMP_B:  read_val = buf_val[1];
      ADDR_ASYNC:  read_val = {7'h00, r.async_clock_select};
      ADDR_FLAGS:  read_val = {5'h00, r.interrupt_flag_reg};
      ADDR_MASK:   read_val = {5'h00, r.interrupt_mask_reg};
      default:     read_val = RST_BYTE;
    endcase
  end

  always_comb begin
    nxt = r;
    nxt.rdata = req_i.rd ? read_val : RST_BYTE;
    if (req_i.wr) begin
      case (req_i.addr)
        ADDR_CTRL_A: nxt.control_reg_a = req_i.wdata;
        ADDR_CTRL_B: begin
          nxt.clock_select_field = req_i.wdata[CB_CS_LO +: 3];
          nxt.waveform_mode_bit2 = req_i.wdata[CB_WGM2];
        end
        ADDR_ASYNC:  nxt.async_clock_select = req_i.wdata[AS_SEL];
        ADDR_MASK:   nxt.interrupt_mask_reg = req_i.wdata[2:0];
        default:     nxt.rdata = nxt.rdata;
      endcase
    end
    // R18 a tick consumes the block
    if (timer_tick) begin
      nxt.block = 1'b0;
    end
    // R10 counting per mode on each tick
    if (timer_tick) begin
      if (phase_mode) begin
        if (!r.down && at_top) begin
          nxt.down        = 1'b1;
          nxt.count_value = r.count_value - CNT_ONE;
        end else if (r.down && at_bottom) begin
          nxt.down        = 1'b0;
          nxt.count_value = r.count_value + CNT_ONE;
        end else if (r.down) begin
          nxt.count_value = r.count_value - CNT_ONE;
        end else begin
          nxt.count_value = r.count_value + CNT_ONE;
        end
      end else begin
        nxt.down = 1'b0;
        // R02 R23 R24 R25 clear at top, else wrap past the maximum
        nxt.count_value = at_top ? CNT_BOTTOM : r.count_value + CNT_ONE;
      end
    end
    // R08 R09 R18 software write wins and arms the block
    if (count_wr) begin
      nxt.count_value = req_i.wdata;
      nxt.block       = 1'b1;
    end
    // R05 R12 set wins over clear
    nxt.interrupt_flag_reg = (r.interrupt_flag_reg & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  // R05 R13 each request gated by its mask
  assign irq_o              = r.interrupt_flag_reg & r.interrupt_mask_reg;
  assign rdata_o            = r.rdata;
  assign compare_output_a_o = oc[0];
  assign compare_output_b_o = oc[1];

  // Helper: a count write seen since the last tick, kept apart from the design's own block
  logic blk_seen_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blk_seen_r <= 1'b0;
    end else if (count_wr) begin
      blk_seen_r <= 1'b1;
    end else if (timer_tick) begin
      blk_seen_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_write_wins: assert property ( // R09
    count_wr |=> r.count_value == $past(req_i.wdata))
    else $error("count write did not win");

  a_stopped_hold: assert property ( // R07
    (r.clock_select_field == CS_STOP) && !count_wr |=> $stable(r.count_value))
    else $error("count moved while stopped");

  a_normal_wrap: assert property ( // R23
    timer_tick && (waveform_mode_field == MODE_NORMAL) && (r.count_value == CNT_MAX) &&
    !count_wr |=> (r.count_value == CNT_BOTTOM) && r.interrupt_flag_reg[FL_OVF])
    else $error("normal wrap or overflow flag wrong");

  a_ctc_clear: assert property ( // R24
    timer_tick && (waveform_mode_field == MODE_CTC) && (r.count_value == cmp_val[0]) &&
    !count_wr |=> r.count_value == CNT_BOTTOM)
    else $error("clear on compare A missing");

  a_fast_top: assert property ( // R25
    timer_tick && (waveform_mode_field == MODE_FAST_MAX) && (r.count_value == CNT_MAX) &&
    !count_wr |=> r.count_value == CNT_BOTTOM)
    else $error("fast mode did not restart");

  a_block_match: assert property ( // R18
    blk_seen_r && timer_tick |-> match_evt == '0)
    else $error("match not blocked after count write");

  a_match_flag: assert property ( // R12
    match_evt[0] |=> r.interrupt_flag_reg[FL_BIT[0]])
    else $error("match flag not set");

  a_ack_clear: assert property ( // R28
    irq_ack_i[FL_OVF] && !ovf_evt |=> !r.interrupt_flag_reg[FL_OVF] && !irq_o[FL_OVF])
    else $error("acknowledge did not clear flag");

  a_dbuf_hold: assert property ( // R15
    phase_mode && !(timer_tick && at_top) && $stable(waveform_mode_field)
    |=> $stable(cmp_val[0]))
    else $error("buffered compare changed off top");

  c_overflow: cover property (ovf_evt);
  c_ctc_match: cover property ((waveform_mode_field == MODE_CTC) && match_evt[0]);
  c_turn_down: cover property (phase_mode && $rose(r.down));
endmodule : timer8
`default_nettype wire

/* verif/timer8_tb.sv */
// Self-checking testbench for the 8-bit timer/counter
`timescale 1ns/1ns
`default_nettype none
module timer8_tb import tc8_pkg::*;;
  logic        clk_i;
  logic        rst_n_i;
  reg_req_t    req;
  logic [7:0]  rdata;
  logic        xtal;
  logic        xtal_out;
  logic        oc_a;
  logic        oc_b;
  logic [2:0]  irq;
  logic [2:0]  ack;
  logic        xen;
  logic        pend;
  logic [15:0] note;
  logic [15:0] expq[$];
  logic [7:0]  v;
  logic        ea;
  logic [1:0]  seq[8];
  int          errors;
  int          samples_checked;

  timer8 u_timer8 (
    .clk_i             (clk_i),
    .rst_n_i           (rst_n_i),
    .req_i             (req),
    .rdata_o           (rdata),
    .crystal_osc_in_i  (xtal),
    .crystal_osc_out_o (xtal_out),
    .compare_output_a_o(oc_a),
    .compare_output_b_o(oc_b),
    .irq_o             (irq),
    .irq_ack_i         (ack)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Crystal moves only while enabled, slower than clk/2
  initial begin
    xtal = 1'b0;
    forever begin
      repeat (8) @(posedge clk_i);
      if (xen) xtal <= ~xtal;
    end
  end

  task automatic fail(input string msg);
    errors++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask : fail

  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) fail(msg);
  endtask : chk

  task automatic conclude;
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic run(input int n);
    repeat (n) @(posedge clk_i);
  endtask : run

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req <= '0;
  endtask : wr

  // Expected value noted with a mask of the bits that are fixed
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    expq.push_back({m, e});
    @(posedge clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req <= '0;
  endtask : rd

  // Read data stand only in the cycle after the strobe; sampled mid-cycle
  always @(negedge clk_i) begin
    if (pend) begin
      samples_checked++;
      if (expq.size() == 0) begin
        fail("read data with no expectation");
      end else begin
        note = expq.pop_front();
        if ((rdata & note[15:8]) !== note[7:0]) begin
          fail($sformatf("read %h expected %h mask %h", rdata, note[7:0], note[15:8]));
        end
      end
    end
    pend = req.rd;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fail("run did not finish in time");
    conclude();
  end

  initial begin
    rst_n_i = 1'b0;
    req = '0;
    ack = 3'h0;
    xen = 1'b0;
    pend = 1'b0;
    errors = 0;
    samples_checked = 0;
    seq = '{2'h1, 2'h3, 2'h0, 2'h1, 2'h3, 2'h0, 2'h2, 2'h3};
    void'($urandom(32'hD20BB8E5));
    run(6);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[3:0], 8'h00, 8'hFF);
    wr(4'h9, 8'hAA);
    rd(4'h9, 8'h00, 8'hFF);
    chk(irq === 3'h0 && oc_a === 1'b0 && oc_b === 1'b0, "outputs after reset");
    repeat (4) begin
      v = 8'($urandom());
      wr(ADDR_COUNT, v);
      run(5);
      rd(ADDR_COUNT, v, 8'hFF);
    end
    wr(ADDR_CMP_A, 8'h10);
    wr(ADDR_COUNT, 8'h10);
    wr(ADDR_CTRL_B, 8'h01);
    run(4);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_FLAGS, 8'h00, 8'h02);
    wr(ADDR_COUNT, 8'h0C);
    wr(ADDR_CTRL_B, 8'h01);
    run(6);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_FLAGS, 8'h02, 8'h02);
    wr(ADDR_MASK, 8'h02);
    run(2);
    chk(irq === 3'b010, "match request not raised");
    ack <= 3'b010;
    run(1);
    ack <= 3'b000;
    run(2);
    chk(irq === 3'b000, "request stays after acknowledge");
    rd(ADDR_FLAGS, 8'h00, 8'h02);
    wr(ADDR_COUNT, 8'hFC);
    wr(ADDR_CTRL_B, 8'h01);
    run(8);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_FLAGS, 8'h01, 8'h01);
    rd(ADDR_COUNT, 8'h00, 8'hF0);
    wr(ADDR_MASK, 8'h01);
    run(2);
    chk(irq === 3'b001, "overflow request not raised");
    wr(ADDR_MASK, 8'h00);
    run(2);
    chk(irq === 3'b000, "masked request still seen");
    wr(ADDR_FLAGS, 8'h00);
    rd(ADDR_FLAGS, 8'h01, 8'h01);
    wr(ADDR_FLAGS, 8'h01);
    rd(ADDR_FLAGS, 8'h00, 8'h01);
    // count loaded away from both compare values
    wr(ADDR_CTRL_B, 8'h01);
    run(5);
    wr(ADDR_COUNT, 8'h80);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_COUNT, 8'h80, 8'hFC);
    // Forced matches under every action code, timer stopped
    wr(ADDR_COUNT, 8'h33);
    // Match B fired when the count passed zero; clear it first
    wr(ADDR_FLAGS, 8'h07);
    // output level set up by force before use
    ea = 1'b0;
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_CTRL_A, {seq[k], seq[k], 4'h0});
      wr(ADDR_CTRL_B, 8'hC0);
      run(2);
      case (seq[k])
        2'h1: ea = ~ea;
        2'h2: ea = 1'b0;
        2'h3: ea = 1'b1;
        default: ea = ea;
      endcase
      chk(oc_a === ea && oc_b === ea, "forced output level");
    end
    rd(ADDR_FLAGS, 8'h00, 8'h07);
    rd(ADDR_COUNT, 8'h33, 8'hFF);
    rd(ADDR_CTRL_B, 8'h00, 8'hC0);
    wr(ADDR_CTRL_A, 8'h02);
    chk(oc_a === 1'b1 && oc_b === 1'b1, "output lost on mode change");
    wr(ADDR_CMP_A, 8'h05);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_CTRL_B, 8'h01);
    run(30);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_COUNT, 8'h00, 8'hF8);
    rd(ADDR_FLAGS, 8'h02, 8'h03);
    chk(oc_a === 1'b1, "output moved with action zero");
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_ASYNC, 8'h01);
    rd(ADDR_ASYNC, 8'h01, 8'hFF);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL_B, 8'h01);
    run(20);
    rd(ADDR_COUNT, 8'h00, 8'hFF);
    xen = 1'b1;
    run(40);
    xen = 1'b0;
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_COUNT, 8'h00, 8'hF8);
    wr(ADDR_ASYNC, 8'h00);
    run(3);
    chk(xtal_out === ~xtal, "crystal output not inverse of input");
    if (expq.size() != 0) fail("reads left unanswered");
    conclude();
  end
endmodule : timer8_tb
`default_nettype wire
